// ==== rtl/pemon_core.sv ====
// pemon_core.sv: sample sequencer, averaging, power, energy and extremes
// assumes an external converter answering each request with one
// current/voltage/auxiliary set, and a bus front end giving pulses
`timescale 1ns/1ps
`default_nettype none
`include "pemon_consts.svh"

// Behaviour
// R1: average over 2^N samples, N 0..7
// R2: average power from per-sample products
// R3: signed current, four selectable ranges
// R4: primary voltage range from three options
// R5: auxiliary voltage fixed range only
// R6: ranges come from the setup command
// R7: single shot samples, averages, then stops
// R8: continuous mode samples forever, newest shown
// R9: convert bit starts one single shot
// R10: group convert waits for bus stop
// R11: trigger pin starts a single shot
// R12: product of each pair is input power
// R13: power accumulates, overflow bumps rollover
// R14: each accumulation bumps sample counter
// R15: energy read returns coherent snapshot
// R16: track peaks, minima and maxima
// R17: 7-bit address from two pins
// R18: each pin resolves to four states
// R19: pin codes map in order, high first
// R20: single shot ignored while one runs
module pemon_core (
    input wire logic ref_clk,
    input wire logic rst,
    // configuration from the setup command
    input wire logic setup_write,
    input wire logic setup_continuous,
    input wire logic [2:0] setup_avg_exp,
    input wire logic [1:0] setup_current_range,
    input wire logic [1:0] setup_voltage_range,
    input wire logic setup_trigger_pin_enable,
    // trigger command
    input wire logic trigger_convert_write,
    input wire logic trigger_in_group,
    input wire logic bus_stop,
    input wire logic multifunction_pin_one,
    // converter handshake
    output logic sample_trigger_pin_request,
    input wire logic sample_trigger_pin_valid,
    input wire logic [11:0] sample_trigger_pin_current,
    input wire logic [11:0] sample_trigger_pin_voltage,
    input wire logic [11:0] sample_trigger_pin_aux,
    // range steering to the analog front end
    output logic [1:0] current_range,
    output logic [1:0] voltage_range,
    // address pins
    input wire logic [1:0] address_select_low_pin,
    input wire logic [1:0] address_select_high_pin,
    output logic [6:0] bus_address,
    // readings
    output logic [11:0] avg_current,
    output logic [11:0] avg_voltage,
    output logic [11:0] avg_aux,
    output logic [23:0] avg_power,
    output logic result_ready,
    output logic busy,
    // energy snapshot
    input wire logic energy_read,
    output logic [23:0] energy_acc,
    output logic [7:0] energy_rollover,
    output logic [23:0] energy_count,
    // extremes
    input wire logic clear_peaks,
    output logic [11:0] peak_voltage,
    output logic [11:0] peak_aux,
    output logic [11:0] lowest_current,
    output logic [11:0] highest_current,
    output logic [23:0] lowest_power,
    output logic [23:0] highest_power
);
    // ==========================================================
    // all state in one struct
    typedef struct packed {
        pemon_pkg::pemon_state_t state;
        logic continuous;
        logic [2:0] avg_exp;
        logic [1:0] irange;
        logic [1:0] vrange;
        logic pin_en;
        logic pend_group;
        logic pin_s1;
        logic pin_s2;
        logic pin_s3;
        logic [7:0] cnt;
        logic signed [`PEMON_SUM_W-1:0] sum_i;
        logic [`PEMON_SUM_W-1:0] sum_v;
        logic [`PEMON_SUM_W-1:0] sum_a;
        logic signed [`PEMON_SUM_W+7:0] sum_p;
        logic req;
        logic [11:0] o_i;
        logic [11:0] o_v;
        logic [11:0] o_a;
        logic [23:0] o_p;
        logic ready;
        logic [`PEMON_ACC_W-1:0] acc;
        logic [`PEMON_ROLL_W-1:0] roll;
        logic [`PEMON_CNT_W-1:0] scnt;
        logic [23:0] snap_acc;
        logic [7:0] snap_roll;
        logic [23:0] snap_cnt;
        logic [11:0] pk_v;
        logic [11:0] pk_a;
        logic [11:0] mn_i;
        logic [11:0] mx_i;
        logic [23:0] mn_p;
        logic [23:0] mx_p;
        logic busy;
    } pemon_core_state_t;

    pemon_core_state_t st_reg;
    pemon_core_state_t st_next;

    // per-sample product, signed current times unsigned voltage
    logic signed [23:0] prod;
    logic signed [24:0] prod_full;
    logic [`PEMON_ACC_W:0] acc_sum;
    logic [7:0] target;
    logic start_req;
    logic pin_rise;

    // ==========================================================
    // combinational helpers
    // truncating the 25-bit product keeps 24 bits; 12x12 signed fits 24
    assign prod_full = $signed(sample_trigger_pin_current) * $signed({1'b0, sample_trigger_pin_voltage}); // [R12] [R3]
    assign prod = prod_full[23:0];
    // energy adds positive products only; a negative product adds zero, not accumulated as debit
    assign acc_sum = {1'b0, st_reg.acc} + {1'b0, (prod[23] ? 24'h000000 : prod)};
    assign target = 8'h01 << st_reg.avg_exp; // [R1]
    // pin edge read only from second and third stages
    assign pin_rise = st_reg.pin_s2 & ~st_reg.pin_s3;
    always_comb begin
        start_req = 1'b0;
        if (!st_reg.continuous) begin
            if (trigger_convert_write && !trigger_in_group) begin
                start_req = 1'b1; // [R9]
            end
            if (bus_stop && st_reg.pend_group) begin
                start_req = 1'b1; // [R10]
            end
            if (st_reg.pin_en && pin_rise) begin
                start_req = 1'b1; // [R11]
            end
        end
    end

    // ==========================================================
    // next-state logic
    always_comb begin
        st_next = st_reg;
        st_next.pin_s1 = multifunction_pin_one;
        st_next.pin_s2 = st_reg.pin_s1;
        st_next.pin_s3 = st_reg.pin_s2;
        st_next.req = 1'b0;
        st_next.ready = 1'b0;

        // setup command loads ranges and mode; aux has no range field [R6] [R5]
        if (setup_write) begin
            st_next.continuous = setup_continuous;
            st_next.avg_exp = (setup_avg_exp > `PEMON_AVG_MAX) ? `PEMON_AVG_MAX : setup_avg_exp;
            st_next.irange = setup_current_range; // [R3]
            // reserved code falls back to the widest range
            st_next.vrange = (setup_voltage_range == 2'h3) ? 2'h2 : setup_voltage_range; // [R4]
            st_next.pin_en = setup_trigger_pin_enable;
        end

        // group convert held until the stop condition [R10]
        if (trigger_convert_write && trigger_in_group && !st_reg.continuous) begin
            st_next.pend_group = 1'b1;
        end else if (bus_stop) begin
            st_next.pend_group = 1'b0;
        end

        case (st_reg.state)
            pemon_pkg::PEMON_IDLE: begin
                if (st_reg.continuous || start_req) begin // [R8] [R9]
                    st_next.state = pemon_pkg::PEMON_REQ;
                    st_next.cnt = 8'h00;
                    st_next.sum_i = '0;
                    st_next.sum_v = '0;
                    st_next.sum_a = '0;
                    st_next.sum_p = '0;
                end
            end
            pemon_pkg::PEMON_REQ: begin
                // starts arriving here are dropped [R20]
                st_next.req = 1'b1;
                st_next.state = pemon_pkg::PEMON_WAIT;
            end
            pemon_pkg::PEMON_WAIT: begin
                if (sample_trigger_pin_valid) begin
                    st_next.sum_i = st_reg.sum_i + `PEMON_SUM_W'($signed(sample_trigger_pin_current));
                    st_next.sum_v = st_reg.sum_v + `PEMON_SUM_W'(sample_trigger_pin_voltage);
                    st_next.sum_a = st_reg.sum_a + `PEMON_SUM_W'(sample_trigger_pin_aux);
                    st_next.sum_p = st_reg.sum_p + (`PEMON_SUM_W+8)'(prod); // [R2]
                    st_next.cnt = st_reg.cnt + 8'h01;
                    // energy accumulation with rollover and sample count [R13] [R14]
                    st_next.acc = acc_sum[`PEMON_ACC_W-1:0];
                    if (acc_sum[`PEMON_ACC_W]) begin
                        st_next.roll = st_reg.roll + 8'h01; // [R13]
                    end
                    st_next.scnt = st_reg.scnt + 24'h000001; // [R14]
                    if (st_reg.cnt + 8'h01 == target) begin
                        // 2^N average by right shift, arithmetic for current and power, logical for voltage and aux [R1] [R2]
                        st_next.o_i = 12'(st_next.sum_i >>> st_reg.avg_exp);
                        st_next.o_v = 12'(st_next.sum_v >> st_reg.avg_exp);
                        st_next.o_a = 12'(st_next.sum_a >> st_reg.avg_exp);
                        st_next.o_p = 24'(st_next.sum_p >>> st_reg.avg_exp); // [R12]
                        st_next.ready = 1'b1;
                        // single shot stops, continuous rearms [R7] [R8]
                        st_next.state = st_reg.continuous ? pemon_pkg::PEMON_REQ
                                                          : pemon_pkg::PEMON_IDLE;
                        st_next.cnt = 8'h00;
                        st_next.sum_i = '0;
                        st_next.sum_v = '0;
                        st_next.sum_a = '0;
                        st_next.sum_p = '0;
                    end else begin
                        st_next.state = pemon_pkg::PEMON_REQ;
                    end
                end
            end
            default: begin
                st_next.state = pemon_pkg::PEMON_IDLE;
            end
        endcase
        // busy registered so the port comes straight from a flip-flop
        st_next.busy = (st_next.state != pemon_pkg::PEMON_IDLE);

        // extremes track each averaged result; clear loses to a same-cycle update [R16]
        if (clear_peaks) begin
            st_next.pk_v = `PEMON_ZERO_V;
            st_next.pk_a = `PEMON_ZERO_V;
            st_next.mn_i = `PEMON_MIN_RESET_I;
            st_next.mx_i = `PEMON_MAX_RESET_I;
            st_next.mn_p = `PEMON_MIN_RESET_P;
            st_next.mx_p = `PEMON_ZERO_P;
        end
        if (st_next.ready) begin
            if (st_next.o_v > st_next.pk_v) st_next.pk_v = st_next.o_v;
            if (st_next.o_a > st_next.pk_a) st_next.pk_a = st_next.o_a;
            if ($signed(st_next.o_i) < $signed(st_next.mn_i)) st_next.mn_i = st_next.o_i;
            if ($signed(st_next.o_i) > $signed(st_next.mx_i)) st_next.mx_i = st_next.o_i;
            // reset marker compared after a same-cycle clear, so the update still wins
            if ($signed(st_next.o_p) < $signed(st_next.mn_p) || st_next.mn_p == `PEMON_MIN_RESET_P) begin
                st_next.mn_p = st_next.o_p;
            end
            if ($signed(st_next.o_p) > $signed(st_next.mx_p)) st_next.mx_p = st_next.o_p;
        end

        // snapshot taken at the read so all three fields match [R15]
        if (energy_read) begin
            st_next.snap_acc = st_reg.acc;
            st_next.snap_roll = st_reg.roll;
            st_next.snap_cnt = st_reg.scnt;
        end
    end

    // ==========================================================
    // state register
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            st_reg <= '0;
            st_reg.state <= pemon_pkg::PEMON_IDLE;
            st_reg.mn_i <= `PEMON_MIN_RESET_I;
            st_reg.mx_i <= `PEMON_MAX_RESET_I;
            st_reg.mn_p <= `PEMON_MIN_RESET_P;
        end else begin
            st_reg <= st_next;
        end
    end

    // ==========================================================
    // address decode [R17]
    pemon_addr_decode u_addr (
        .ref_clk(ref_clk),
        .rst(rst),
        .address_select_low_pin(address_select_low_pin),
        .address_select_high_pin(address_select_high_pin),
        .bus_address(bus_address)
    );

    // outputs straight from the state register
    assign sample_trigger_pin_request = st_reg.req;
    assign current_range = st_reg.irange;
    assign voltage_range = st_reg.vrange;
    assign avg_current = st_reg.o_i;
    assign avg_voltage = st_reg.o_v;
    assign avg_aux = st_reg.o_a;
    assign avg_power = st_reg.o_p;
    assign result_ready = st_reg.ready;
    assign busy = st_reg.busy;
    assign energy_acc = st_reg.snap_acc;
    assign energy_rollover = st_reg.snap_roll;
    assign energy_count = st_reg.snap_cnt;
    assign peak_voltage = st_reg.pk_v;
    assign peak_aux = st_reg.pk_a;
    assign lowest_current = st_reg.mn_i;
    assign highest_current = st_reg.mx_i;
    assign lowest_power = st_reg.mn_p;
    assign highest_power = st_reg.mx_p;
endmodule
`default_nettype wire

// ==== rtl/pemon_consts.svh ====
// pemon_consts.svh: named constants for the power and energy monitor core
// assumes it is included by bare name from files under rtl/
`ifndef PEMON_CONSTS_SVH
`define PEMON_CONSTS_SVH

// ==========================================================
// widths
`define PEMON_SAMPLE_W 12
`define PEMON_POWER_W 24
`define PEMON_SUM_W 31
`define PEMON_ACC_W 24
`define PEMON_ROLL_W 8
`define PEMON_CNT_W 24
`define PEMON_AVG_MAX 3'h7

// ==========================================================
// address building
`define PEMON_ADDR_BASE 3'h3
`define PEMON_PIN_LOW 2'h0
`define PEMON_PIN_RES 2'h1
`define PEMON_PIN_FLOAT 2'h2
`define PEMON_PIN_HIGH 2'h3

// ==========================================================
// reset values
`define PEMON_MIN_RESET_I 12'h7FF
`define PEMON_MAX_RESET_I 12'h800
`define PEMON_MIN_RESET_P 24'hFFFFFF
`define PEMON_ZERO_P 24'h000000
`define PEMON_ZERO_V 12'h000

`endif

// ==== rtl/pemon_pkg.sv ====
// pemon_pkg.sv: shared types of the power and energy monitor core
// assumes pemon_consts.svh sits beside it
`include "pemon_consts.svh"

package pemon_pkg;
    // ==========================================================
    // sequencing states
    typedef enum logic [1:0] {
        PEMON_IDLE,
        PEMON_REQ,
        PEMON_WAIT
    } pemon_state_t;

    // current sense full-scale ranges
    typedef enum logic [1:0] {
        PEMON_I_25MV,
        PEMON_I_50MV,
        PEMON_I_100MV,
        PEMON_I_200MV
    } pemon_irange_t;

    // primary voltage full-scale ranges
    typedef enum logic [1:0] {
        PEMON_V_1V2,
        PEMON_V_7V6,
        PEMON_V_21V
    } pemon_vrange_t;
endpackage

// ==== rtl/pemon_addr_decode.sv ====
// pemon_addr_decode.sv: forms the 7-bit bus address from two four-level pins
// assumes the pin states come already resolved by the analog front end
`timescale 1ns/1ps
`default_nettype none
`include "pemon_consts.svh"

module pemon_addr_decode (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [1:0] address_select_low_pin,
    input wire logic [1:0] address_select_high_pin,
    output logic [6:0] bus_address
);
    // ==========================================================
    // synchronise pin states, then register the address
    typedef struct packed {
        logic [3:0] sync1;
        logic [3:0] sync2;
        logic [6:0] addr;
    } pemon_adr_state_t;

    pemon_adr_state_t st_reg;
    pemon_adr_state_t st_next;

    // pin code order is ground, resistor, floating, rail [R18] [R19]
    always_comb begin
        st_next = st_reg;
        st_next.sync1 = {address_select_high_pin, address_select_low_pin};
        st_next.sync2 = st_reg.sync1;
        st_next.addr = {`PEMON_ADDR_BASE, st_reg.sync2}; // [R17]
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign bus_address = st_reg.addr;
endmodule
`default_nettype wire

// ==== tb/pemon_core_asserts.sv ====
// port checker for the monitor core
// assumes a bind from the bench top file
`timescale 1ns/1ps
`default_nettype none
module pemon_core_asserts (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [1:0] address_select_low_pin,
    input wire logic [1:0] address_select_high_pin,
    input wire logic [6:0] bus_address,
    input wire logic sample_trigger_pin_request,
    input wire logic sample_trigger_pin_valid,
    input wire logic busy,
    input wire logic result_ready,
    input wire logic [11:0] avg_voltage,
    input wire logic [23:0] avg_power,
    input wire logic energy_read,
    input wire logic [23:0] energy_count,
    input wire logic clear_peaks,
    input wire logic [11:0] peak_voltage
);
    // ==========================================================
    // pin hold counter: the decoder needs settled pins first
    logic [3:0] pins_q;
    logic [2:0] hold_cnt;
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            pins_q <= 4'h0;
            hold_cnt <= 3'h0;
        end else begin
            pins_q <= {address_select_high_pin, address_select_low_pin};
            if (pins_q != {address_select_high_pin, address_select_low_pin}) begin
                hold_cnt <= 3'h0;
            end else if (hold_cnt != 3'h5) begin
                hold_cnt <= hold_cnt + 3'h1;
            end
        end
    end

    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);

    addr_map_a: assert property (hold_cnt == 3'h5 |-> bus_address == {3'h3, pins_q})
        else $error("bus address does not follow pins");
    req_pulse_a: assert property (sample_trigger_pin_request |=> !sample_trigger_pin_request)
        else $error("conversion request longer than one cycle");
    ready_pulse_a: assert property (result_ready |=> !result_ready)
        else $error("result flag longer than one cycle");
    ready_cause_a: assert property (result_ready |-> $past(sample_trigger_pin_valid))
        else $error("result without a final sample");
    start_req_a: assert property ($rose(busy) |=> sample_trigger_pin_request)
        else $error("start not followed by a request");
    avg_hold_a: assert property (!result_ready |-> $stable(avg_power))
        else $error("average power moved without a result");
    snap_hold_a: assert property (!energy_read |=> $stable(energy_count))
        else $error("energy snapshot moved without a read");
    peak_track_a: assert property (result_ready |-> peak_voltage >= avg_voltage)
        else $error("peak voltage below result");
    peak_mono_a: assert property (!clear_peaks |=> peak_voltage >= $past(peak_voltage))
        else $error("peak voltage fell without a clear");
endmodule
`default_nettype wire

// ==== tb/pemon_sample_trigger_pin_model.sv ====
// converter model answering each request with one sample set
// assumes the bench sets base values; alt toggles a +1 offset per sample
`timescale 1ns/1ps
`default_nettype none
module pemon_sample_trigger_pin_model (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic sample_trigger_pin_request,
    input wire logic slow,
    input wire logic alt,
    input wire logic [11:0] i_base,
    input wire logic [11:0] v_base,
    input wire logic [11:0] a_base,
    output logic sample_trigger_pin_valid,
    output logic [11:0] sample_trigger_pin_current,
    output logic [11:0] sample_trigger_pin_voltage,
    output logic [11:0] sample_trigger_pin_aux
);
    // ==========================================================
    logic pend;
    logic k;
    logic [3:0] wait_cnt;
    // one answer per request, quick or after a stall
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            pend <= 1'b0;
            k <= 1'b0;
            wait_cnt <= 4'h0;
            sample_trigger_pin_valid <= 1'b0;
        end else begin
            sample_trigger_pin_valid <= 1'b0;
            if (sample_trigger_pin_valid) begin
                k <= alt & ~k;
            end
            if (sample_trigger_pin_request) begin
                pend <= 1'b1;
                wait_cnt <= slow ? 4'h6 : 4'h0;
            end else if (pend && wait_cnt != 4'h0) begin
                wait_cnt <= wait_cnt - 4'h1;
            end else if (pend) begin
                pend <= 1'b0;
                sample_trigger_pin_valid <= 1'b1;
            end
        end
    end
    // lines show the inverse outside the valid cycle, never stale data
    assign sample_trigger_pin_current = sample_trigger_pin_valid ? i_base + 12'(k) : ~(i_base + 12'(k));
    assign sample_trigger_pin_voltage = sample_trigger_pin_valid ? v_base + 12'(k) : ~(v_base + 12'(k));
    assign sample_trigger_pin_aux = sample_trigger_pin_valid ? a_base : ~a_base;
endmodule
`default_nettype wire

// ==== tb/tb_pemon_core.sv ====
// bench for the monitor core with a converter model
// assumes the core and its package are compiled first
`timescale 1ns/1ps
`default_nettype none
module tb_pemon_core;
    logic ref_clk, rst, setup_write, setup_continuous, setup_trigger_pin_enable;
    logic [2:0] setup_avg_exp;
    logic [1:0] setup_current_range, setup_voltage_range, current_range, voltage_range;
    logic trigger_convert_write, trigger_in_group, bus_stop, multifunction_pin_one;
    logic sample_trigger_pin_request, sample_trigger_pin_valid, result_ready, busy, energy_read, clear_peaks;
    logic [11:0] sample_trigger_pin_current, sample_trigger_pin_voltage, sample_trigger_pin_aux, avg_current, avg_voltage, avg_aux;
    logic [11:0] peak_voltage, peak_aux, lowest_current, highest_current;
    logic [1:0] address_select_low_pin, address_select_high_pin;
    logic [6:0] bus_address;
    logic [23:0] avg_power, energy_acc, energy_count, lowest_power, highest_power;
    logic [7:0] energy_rollover;
    logic slow, alt;
    logic [11:0] i_base, v_base, a_base;
    int err_count, comparisons, req_n, p;
    logic [24:0] acc_sum;
    logic [7:0] roll;
    logic [23:0] cnt;

    pemon_core u_pemon_core (.ref_clk, .rst, .setup_write, .setup_continuous,
        .setup_avg_exp, .setup_current_range, .setup_voltage_range,
        .setup_trigger_pin_enable, .trigger_convert_write, .trigger_in_group, .bus_stop,
        .multifunction_pin_one, .sample_trigger_pin_request, .sample_trigger_pin_valid, .sample_trigger_pin_current, .sample_trigger_pin_voltage,
        .sample_trigger_pin_aux, .current_range, .voltage_range, .address_select_low_pin,
        .address_select_high_pin, .bus_address, .avg_current, .avg_voltage, .avg_aux,
        .avg_power, .result_ready, .busy, .energy_read, .energy_acc, .energy_rollover,
        .energy_count, .clear_peaks, .peak_voltage, .peak_aux, .lowest_current,
        .highest_current, .lowest_power, .highest_power);
    pemon_sample_trigger_pin_model u_pemon_sample_trigger_pin_model (.ref_clk, .rst, .sample_trigger_pin_request, .slow, .alt,
        .i_base, .v_base, .a_base, .sample_trigger_pin_valid, .sample_trigger_pin_current, .sample_trigger_pin_voltage, .sample_trigger_pin_aux);

    // ==========================================================
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    // own energy and request tally, built from the converter side
    always @(posedge ref_clk) begin
        if (sample_trigger_pin_request) req_n++;
        if (!rst && sample_trigger_pin_valid) begin
            p = $signed(sample_trigger_pin_current) * $signed({1'b0, sample_trigger_pin_voltage});
            acc_sum = {1'b0, acc_sum[23:0]} + ((p > 0) ? 25'(p) : 25'h0);
            roll = roll + 8'(acc_sum[24]);
            cnt = cnt + 24'h1;
        end
    end
    task automatic cyc(input int n);
        repeat (n) @(negedge ref_clk);
    endtask
    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        comparisons++;
        if (got !== exp) begin
            err_count++;
            $display("Error %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic write_setup(input logic c, input logic [2:0] n, input logic [1:0] r);
        {setup_continuous, setup_avg_exp, setup_current_range, setup_voltage_range} = {c, n, r, r};
        setup_write = 1'b1;
        cyc(1);
        setup_write = 1'b0;
    endtask
    task automatic write_trigger();
        trigger_convert_write = 1'b1;
        cyc(1);
        trigger_convert_write = 1'b0;
    endtask
    task automatic read_result();
        int i;
        for (i = 0; i < 3000 && result_ready !== 1'b1; i++) cyc(1);
        chk(24'(result_ready), 24'h1);
        cyc(1);
    endtask
    task automatic tally_and_finish();
        $display("comparisons %0d errors %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        #500000;
        err_count++;
        tally_and_finish();
    end

    // ==========================================================
    initial begin
        {setup_write, setup_continuous, setup_avg_exp, setup_current_range} = 0;
        {setup_voltage_range, setup_trigger_pin_enable, trigger_convert_write} = 0;
        {trigger_in_group, bus_stop, multifunction_pin_one, energy_read, clear_peaks} = 0;
        {address_select_low_pin, address_select_high_pin, slow, alt} = 0;
        {i_base, v_base, a_base, err_count, comparisons, acc_sum, roll, cnt} = 0;
        rst = 1'b1;
        cyc(4);
        rst = 1'b0;
        chk(24'(lowest_current), 24'h7FF);
        chk(24'(highest_current), 24'h800);
        chk(lowest_power, 24'hFFFFFF);
        for (int a = 0; a < 16; a++) begin
            {address_select_high_pin, address_select_low_pin} = 4'(a);
            cyc(5);
            chk(24'(bus_address), 24'(7'h30 + a));
        end
        for (int r = 0; r < 4; r++) begin
            write_setup(1'b0, 3'h0, 2'(r));
            chk(24'(current_range), 24'(r));
            chk(24'(voltage_range), (r == 3) ? 24'h2 : 24'(r));
        end
        {alt, i_base, v_base, a_base} = {1'b1, 12'h00A, 12'h00C, 12'h032};
        for (int n = 1; n < 8; n++) begin
            write_setup(1'b0, 3'(n), 2'h0);
            req_n = 0;
            write_trigger();
            cyc(3);
            write_trigger();
            read_result();
            chk(24'(req_n), 24'(1 << n));
            chk(avg_power, 24'((10 * 12 + 11 * 13) / 2));
            chk({12'h0, avg_current, avg_aux}, 24'h00A032);
            chk(24'(avg_voltage), 24'h00C);
            cyc(20);
            chk(24'(req_n + busy), 24'(1 << n));
        end
        {alt, slow, i_base, v_base} = {1'b0, 1'b1, 12'hFFC, 12'h064};
        write_setup(1'b0, 3'h0, 2'h3);
        write_trigger();
        read_result();
        chk(avg_power, 24'hFFFE70);
        trigger_in_group = 1'b1;
        write_trigger();
        trigger_in_group = 1'b0;
        cyc(5);
        chk(24'(busy), 24'h0);
        bus_stop = 1'b1;
        cyc(1);
        bus_stop = 1'b0;
        read_result();
        setup_trigger_pin_enable = 1'b1;
        write_setup(1'b0, 3'h0, 2'h0);
        multifunction_pin_one = 1'b1;
        read_result();
        {multifunction_pin_one, slow, i_base, v_base} = {1'b0, 1'b0, 12'h3E8, 12'hFA0};
        write_setup(1'b1, 3'h0, 2'h2);
        read_result();
        read_result();
        chk(avg_power, 24'h3D0900);
        cyc(40);
        write_setup(1'b0, 3'h0, 2'h2);
        cyc(20);
        chk(24'(busy), 24'h0);
        chk({peak_voltage, lowest_current}, 24'hFA0FFC);
        chk({peak_aux, highest_current}, 24'h0323E8);
        chk(highest_power, 24'h3D0900);
        chk(lowest_power, 24'hFFFE70);
        clear_peaks = 1'b1;
        cyc(1);
        clear_peaks = 1'b0;
        chk(24'(peak_voltage), 24'h0);
        chk(highest_power, 24'h0);
        chk(24'(highest_current), 24'h800);
        energy_read = 1'b1;
        cyc(1);
        energy_read = 1'b0;
        chk(energy_acc, acc_sum[23:0]);
        chk(24'(energy_rollover), 24'(roll));
        chk(energy_count, cnt);
        tally_and_finish();
    end
endmodule
bind pemon_core pemon_core_asserts u_pemon_core_asserts (.ref_clk, .rst,
    .address_select_low_pin, .address_select_high_pin, .bus_address, .sample_trigger_pin_request,
    .sample_trigger_pin_valid, .busy, .result_ready, .avg_voltage, .avg_power, .energy_read,
    .energy_count, .clear_peaks, .peak_voltage);
`default_nettype wire
